// ===== src/scis_pkg.sv
// Constants and types for the servo control input select block
// Behaviour
// - General pulse pair is used only while the source select is 0 (default).
// - Line-driver-only pulse pair is used only while the source select is 1.
// - Each of ten sequence inputs gets function and sense from its allocation.
// - Reverse inhibit acts only when drive inhibit mode is 0 or 2.
// - Forward inhibit acts only when drive inhibit mode is 0 or 2.
// - Damping switch A is honoured only when damping filter mode is 1 or 2.
// - Damping mode 2 joins switches B and A into a two-bit filter index.
// - Gain select honoured only when active control mode's gain mode is 2.
// - Gain select inactive picks gain set one, active picks gain set two.
package scis_pkg;

	localparam int NUM_SEQ = 10;
	localparam int NUM_PINS = 14;
	localparam int PIN_GEN_A = 0;
	localparam int PIN_GEN_B = 1;
	localparam int PIN_LD_REV = 2;
	localparam int PIN_LD_FWD = 3;
	localparam int PIN_SEQ_LSB = 4;

	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] ALLOC_OFS = 8'h04;
	localparam logic [7:0] ALLOC_END = 8'h28;
	localparam logic [7:0] STAT_OFS = 8'h2c;

	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK = 32'h000f_fff3;
	localparam logic [4:0] ALLOC_RST = 5'h00;
	localparam int CFG_SRC_BIT = 0;
	localparam int CFG_CMODE_BIT = 1;
	localparam int CFG_INH_LSB = 4;
	localparam int CFG_DF_LSB = 8;
	localparam int CFG_GSP_LSB = 12;
	localparam int CFG_GSS_LSB = 16;
	localparam int ALLOC_INV_BIT = 4;
	localparam int STAT_REV_BIT = 16;
	localparam int STAT_FWD_BIT = 17;
	localparam int STAT_DSEL_LSB = 18;
	localparam int STAT_DEN_BIT = 20;
	localparam int STAT_GAIN_BIT = 21;
	localparam int STAT_GEN_BIT = 22;

	localparam logic SRC_GENERAL = 1'b0;
	localparam logic SRC_LINEDRV = 1'b1;
	localparam logic CMODE_SPEED = 1'b1;
	localparam logic [3:0] INH_MODE_ZERO = 4'h0;
	localparam logic [3:0] INH_MODE_TWO = 4'h2;
	localparam logic [3:0] DF_MODE_ONE = 4'h1;
	localparam logic [3:0] DF_MODE_TWO = 4'h2;
	localparam logic [3:0] GSW_BY_INPUT = 4'h2;

	typedef enum logic [3:0] {
		FN_NONE = 4'h0,
		FN_REV_INH = 4'h1,
		FN_FWD_INH = 4'h2,
		FN_DAMP_A = 4'h3,
		FN_DAMP_B = 4'h4,
		FN_GAIN = 4'h5
	} scis_func_t;

endpackage

// ===== src/scis_input_select.sv
// Servo control input qualification with APB register access
`timescale 1ns/10ps
`default_nettype none

module scis_input_select #(
	parameter int NUM_SEQ = scis_pkg::NUM_SEQ
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reverse_or_feed_pulse_pos,
	input wire logic forward_or_direction_pos,
	input wire logic reverse_pulse_linedrv_pos,
	input wire logic forward_pulse_linedrv_pos,
	input wire logic [NUM_SEQ-1:0] sequence_inputs,
	output logic cmd_pulse_a,
	output logic cmd_pulse_b,
	output logic reverse_drive_inhibit,
	output logic forward_drive_inhibit,
	output logic damping_filter_en,
	output logic [1:0] damping_filter_index,
	output logic gain_input_en,
	output logic gain_bank_select
);

	// ==========================================================
	// Helpers
	function automatic logic seq_func(
		input logic [NUM_SEQ-1:0] lvl,
		input logic [NUM_SEQ-1:0][4:0] map,
		input scis_pkg::scis_func_t fn
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_SEQ; i++) begin
			if (map[i][3:0] == fn) begin
				hit = hit | (lvl[i] ^ map[i][scis_pkg::ALLOC_INV_BIT]);
			end
		end
		return hit;
	endfunction

	function automatic logic [31:0] byte_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction

	// ==========================================================
	// Input synchroniser
	logic [scis_pkg::NUM_PINS-1:0] pins;
	logic [scis_pkg::NUM_PINS-1:0] sync1_q;
	logic [scis_pkg::NUM_PINS-1:0] sync2_q;
	logic [scis_pkg::NUM_PINS-1:0] sync1_d;
	logic [scis_pkg::NUM_PINS-1:0] sync2_d;

	assign pins = {sequence_inputs, forward_pulse_linedrv_pos,
		reverse_pulse_linedrv_pos, forward_or_direction_pos,
		reverse_or_feed_pulse_pos};

	always_comb begin
		sync1_d = pins;
		sync2_d = sync1_q;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ==========================================================
	// Register file and APB slave
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;
	logic [NUM_SEQ-1:0][4:0] alloc_q;
	logic [NUM_SEQ-1:0][4:0] alloc_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [31:0] status;
	logic [31:0] wmask;
	logic alloc_hit;
	logic [3:0] aidx;
	logic rev_q;
	logic fwd_q;
	logic den_q;
	logic [1:0] dsel_q;
	logic gen_q;
	logic gain_q;

	assign alloc_hit = (paddr >= scis_pkg::ALLOC_OFS) &&
		(paddr <= scis_pkg::ALLOC_END) && (paddr[1:0] == 2'b00);
	assign aidx = paddr[5:2] - 4'h1;
	assign wmask = byte_mask(pstrb);

	always_comb begin
		status = 32'h0000_0000;
		status[scis_pkg::NUM_PINS-1:0] = sync2_q;
		status[scis_pkg::STAT_REV_BIT] = rev_q;
		status[scis_pkg::STAT_FWD_BIT] = fwd_q;
		status[scis_pkg::STAT_DSEL_LSB +: 2] = dsel_q;
		status[scis_pkg::STAT_DEN_BIT] = den_q;
		status[scis_pkg::STAT_GAIN_BIT] = gain_q;
		status[scis_pkg::STAT_GEN_BIT] = gen_q;
	end

	always_comb begin
		cfg_d = cfg_q;
		alloc_d = alloc_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (psel && penable && !pready_q) begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			if (paddr == scis_pkg::CFG_OFS) begin
				prdata_d = cfg_q;
			end else if (alloc_hit) begin
				prdata_d = {27'h0, alloc_q[aidx]};
			end else if (paddr == scis_pkg::STAT_OFS && !pwrite) begin
				prdata_d = status;
			end else begin
				pslverr_d = 1'b1;
			end
		end
		if (psel && penable && pready_q && pwrite) begin
			if (paddr == scis_pkg::CFG_OFS) begin
				cfg_d = ((cfg_q & ~wmask) | (pwdata & wmask)) &
					scis_pkg::CFG_MASK;
			end else if (alloc_hit && pstrb[0]) begin
				alloc_d[aidx] = pwdata[4:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= scis_pkg::CFG_RST;
			alloc_q <= {NUM_SEQ{scis_pkg::ALLOC_RST}};
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			alloc_q <= alloc_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ==========================================================
	// Function qualification
	logic src_sel;
	logic cmode;
	logic [3:0] inh_mode;
	logic [3:0] df_mode;
	logic [3:0] gsw_mode;
	logic [NUM_SEQ-1:0] seq;
	logic fn_rev;
	logic fn_fwd;
	logic fn_da;
	logic fn_db;
	logic fn_gain;
	logic inh_en;
	logic cmd_a_q;
	logic cmd_a_d;
	logic cmd_b_q;
	logic cmd_b_d;
	logic rev_d;
	logic fwd_d;
	logic den_d;
	logic [1:0] dsel_d;
	logic gen_d;
	logic gain_d;

	assign src_sel = cfg_q[scis_pkg::CFG_SRC_BIT];
	assign cmode = cfg_q[scis_pkg::CFG_CMODE_BIT];
	assign inh_mode = cfg_q[scis_pkg::CFG_INH_LSB +: 4];
	assign df_mode = cfg_q[scis_pkg::CFG_DF_LSB +: 4];
	assign gsw_mode = (cmode == scis_pkg::CMODE_SPEED) ?
		cfg_q[scis_pkg::CFG_GSS_LSB +: 4] :
		cfg_q[scis_pkg::CFG_GSP_LSB +: 4];
	assign seq = sync2_q[scis_pkg::PIN_SEQ_LSB +: NUM_SEQ];

	always_comb begin
		fn_rev = seq_func(seq, alloc_q, scis_pkg::FN_REV_INH);
		fn_fwd = seq_func(seq, alloc_q, scis_pkg::FN_FWD_INH);
		fn_da = seq_func(seq, alloc_q, scis_pkg::FN_DAMP_A);
		fn_db = seq_func(seq, alloc_q, scis_pkg::FN_DAMP_B);
		fn_gain = seq_func(seq, alloc_q, scis_pkg::FN_GAIN);
		if (src_sel == scis_pkg::SRC_LINEDRV) begin
			cmd_a_d = sync2_q[scis_pkg::PIN_LD_REV];
			cmd_b_d = sync2_q[scis_pkg::PIN_LD_FWD];
		end else begin
			cmd_a_d = sync2_q[scis_pkg::PIN_GEN_A];
			cmd_b_d = sync2_q[scis_pkg::PIN_GEN_B];
		end
		inh_en = (inh_mode == scis_pkg::INH_MODE_ZERO) ||
			(inh_mode == scis_pkg::INH_MODE_TWO);
		rev_d = inh_en & fn_rev;
		fwd_d = inh_en & fn_fwd;
		den_d = (df_mode == scis_pkg::DF_MODE_ONE) ||
			(df_mode == scis_pkg::DF_MODE_TWO);
		case (df_mode)
			scis_pkg::DF_MODE_ONE: begin
				dsel_d = {1'b0, fn_da};
			end
			scis_pkg::DF_MODE_TWO: begin
				dsel_d = {fn_db, fn_da};
			end
			default: begin
				dsel_d = 2'b00;
			end
		endcase
		gen_d = (gsw_mode == scis_pkg::GSW_BY_INPUT);
		gain_d = gen_d & fn_gain;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_a_q <= 1'b0;
			cmd_b_q <= 1'b0;
			rev_q <= 1'b0;
			fwd_q <= 1'b0;
			den_q <= 1'b0;
			dsel_q <= 2'b00;
			gen_q <= 1'b0;
			gain_q <= 1'b0;
		end else begin
			cmd_a_q <= cmd_a_d;
			cmd_b_q <= cmd_b_d;
			rev_q <= rev_d;
			fwd_q <= fwd_d;
			den_q <= den_d;
			dsel_q <= dsel_d;
			gen_q <= gen_d;
			gain_q <= gain_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cmd_pulse_a = cmd_a_q;
	assign cmd_pulse_b = cmd_b_q;
	assign reverse_drive_inhibit = rev_q;
	assign forward_drive_inhibit = fwd_q;
	assign damping_filter_en = den_q;
	assign damping_filter_index = dsel_q;
	assign gain_input_en = gen_q;
	assign gain_bank_select = gain_q;

	// ==========================================================
	// Assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	gen_pair_a: assert property (
		src_sel == scis_pkg::SRC_GENERAL |=>
		cmd_a_q == $past(sync2_q[scis_pkg::PIN_GEN_A]) &&
		cmd_b_q == $past(sync2_q[scis_pkg::PIN_GEN_B]))
		else $error("general pulse pair not followed");

	ld_pair_a: assert property (
		src_sel == scis_pkg::SRC_LINEDRV |=>
		cmd_a_q == $past(sync2_q[scis_pkg::PIN_LD_REV]) &&
		cmd_b_q == $past(sync2_q[scis_pkg::PIN_LD_FWD]))
		else $error("line driver pair not followed");

	inv_sense_a: assert property (
		inh_en && alloc_q[1] == {1'b1, scis_pkg::FN_FWD_INH} &&
		!seq[1] |=> fwd_q)
		else $error("inverted allocation not honoured");

	rev_gate_a: assert property (
		!inh_en |=> !rev_q)
		else $error("reverse inhibit acted while disabled");

	fwd_gate_a: assert property (
		!inh_en |=> !fwd_q)
		else $error("forward inhibit acted while disabled");

	damp_gate_a: assert property (
		df_mode != scis_pkg::DF_MODE_ONE &&
		df_mode != scis_pkg::DF_MODE_TWO |=> !den_q && dsel_q == 2'b00)
		else $error("damping switch acted while disabled");

	damp_pair_a: assert property (
		df_mode == scis_pkg::DF_MODE_TWO |=>
		dsel_q == {$past(fn_db), $past(fn_da)})
		else $error("damping index not formed from both switches");

	gain_gate_a: assert property (
		gsw_mode != scis_pkg::GSW_BY_INPUT |=> !gain_q && !gen_q)
		else $error("gain select acted while disabled");

	gain_bank_a: assert property (
		gen_d |=> gain_q == $past(fn_gain))
		else $error("gain bank does not follow input");

	sync_lat_a: assert property (
		(src_sel == scis_pkg::SRC_GENERAL) [*4] |->
		cmd_a_q == $past(reverse_or_feed_pulse_pos, 3))
		else $error("pulse input latency not three cycles");

	apb_ready_a: assert property (
		psel && penable && !pready_q |=> pready_q ##1 !pready_q)
		else $error("apb ready not a single cycle");

	ld_use_c: cover property (src_sel == scis_pkg::SRC_LINEDRV &&
		$rose(cmd_a_q));
	damp_idx_c: cover property (dsel_q == 2'b11);
	gain_two_c: cover property (gen_q && gain_q);
	slverr_c: cover property (pready_q && pslverr_q);

endmodule

`default_nettype wire

// ===== sim/scis_host_model.sv
// Host controller model driving the pulse and sequence pins
`timescale 1ns/10ps
`default_nettype none

module scis_host_model (
	input wire logic sel,
	input wire logic pa,
	input wire logic pb,
	input wire logic stray,
	input wire logic [9:0] seq,
	output logic reverse_or_feed_pulse_pos,
	output logic forward_or_direction_pos,
	output logic reverse_pulse_linedrv_pos,
	output logic forward_pulse_linedrv_pos,
	output logic [9:0] sequence_inputs
);
	// Pulses go to the selected pair; stray is a commanded miswire
	assign reverse_or_feed_pulse_pos = sel ? stray : pa;
	assign forward_or_direction_pos = sel ? stray : pb;
	assign reverse_pulse_linedrv_pos = sel ? pa : stray;
	assign forward_pulse_linedrv_pos = sel ? pb : stray;
	assign sequence_inputs = seq;
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
// Testbench for the servo control input select block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic sel, pa, pb, stray;
	logic [9:0] seq, sequence_inputs;
	logic reverse_or_feed_pulse_pos, forward_or_direction_pos;
	logic reverse_pulse_linedrv_pos, forward_pulse_linedrv_pos;
	logic cmd_pulse_a, cmd_pulse_b, reverse_drive_inhibit;
	logic forward_drive_inhibit, damping_filter_en, gain_input_en;
	logic gain_bank_select, ex;
	logic [1:0] damping_filter_index, ix;
	logic [31:0] gcfg [4] = '{32'h2000, 32'h20002, 32'h20000, 32'h2002};
	int n_fail, cmp_count;

	scis_input_select scis_input_select_i (.sys_clk, .rst_b, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .reverse_or_feed_pulse_pos, .forward_or_direction_pos,
		.reverse_pulse_linedrv_pos, .forward_pulse_linedrv_pos,
		.sequence_inputs, .cmd_pulse_a, .cmd_pulse_b,
		.reverse_drive_inhibit, .forward_drive_inhibit, .damping_filter_en,
		.damping_filter_index, .gain_input_en, .gain_bank_select);
	scis_host_model scis_host_model_i (.sel, .pa, .pb, .stray, .seq,
		.reverse_or_feed_pulse_pos, .forward_or_direction_pos,
		.reverse_pulse_linedrv_pos, .forward_pulse_linedrv_pos,
		.sequence_inputs);

	// ==========================================
	// Clock and tasks
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic complete_run;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Access phase spans two edges
		chk(k, 32'h2);
	endtask

	// Drive the host pins, then wait past the input synchronisers
	task automatic drv(input logic s, input logic a, input logic b,
		input logic x, input logic [9:0] q);
		@(posedge sys_clk);
		sel <= s;
		pa <= a;
		pb <= b;
		stray <= x;
		seq <= q;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	// ==========================================
	// Tests
	initial begin
		{rst_b, psel, penable, pwrite, sel, pa, pb, stray} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		seq = 10'h000;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		apb(1'b0, scis_pkg::CFG_OFS, 32'h0);
		chk(rd, scis_pkg::CFG_RST);
		apb(1'b0, 8'h30, 32'h0);
		chk({31'h0, err}, 32'h1);
		drv(1'b0, 1'b1, 1'b0, 1'b0, 10'h000);
		chk({cmd_pulse_a, cmd_pulse_b}, 2'b10);
		drv(1'b0, 1'b0, 1'b1, 1'b1, 10'h000);
		chk({cmd_pulse_a, cmd_pulse_b}, 2'b01);
		apb(1'b1, scis_pkg::CFG_OFS, 32'h1);
		drv(1'b1, 1'b1, 1'b0, 1'b1, 10'h000);
		chk({cmd_pulse_a, cmd_pulse_b}, 2'b10);
		apb(1'b1, 8'h04, 32'h01);
		apb(1'b1, 8'h08, 32'h12);
		apb(1'b1, 8'h0c, 32'h03);
		apb(1'b1, 8'h10, 32'h04);
		apb(1'b1, 8'h14, 32'h05);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h12);
		apb(1'b1, scis_pkg::STAT_OFS, 32'h0);
		chk({31'h0, err}, 32'h1);
		drv(1'b0, 1'b0, 1'b0, 1'b0, 10'h001);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, scis_pkg::CFG_OFS, m << 4);
			drv(1'b0, 1'b0, 1'b0, 1'b0, 10'h001);
			ex = (m == 0 || m == 2);
			chk(reverse_drive_inhibit, ex);
			chk(forward_drive_inhibit, ex);
		end
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, scis_pkg::CFG_OFS, m << 8);
			for (int p = 0; p < 4; p++) begin
				drv(1'b0, 1'b0, 1'b0, 1'b0, 10'(p << 2));
				ix = (m == 2) ? p[1:0] : (m == 1) ? {1'b0, p[0]} : 2'b00;
				chk(damping_filter_en, m != 0);
				chk(damping_filter_index, ix);
			end
		end
		for (int g = 0; g < 4; g++) begin
			apb(1'b1, scis_pkg::CFG_OFS, gcfg[g]);
			for (int v = 0; v < 2; v++) begin
				drv(1'b0, 1'b0, 1'b0, 1'b0, 10'(v << 4));
				chk(gain_input_en, g < 2);
				chk(gain_bank_select, g < 2 && v == 1);
			end
		end
		complete_run();
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		complete_run();
	end
endmodule

`default_nettype wire
